/* common/ecg_map.vh */
// Echo canceller group core: offsets, fields, reset values and timing
// Behaviour
// - 32 cancellers as 16 groups of two
// - normal: two independent 64ms channels
// - extended delay: A and B cascaded, 128ms
// - 1024 taps as two 512-tap sections
// - back-to-back: section one receive, two send
// - double talk halts adaptation, cancelling continues
// - uncertain double talk slows adaptation, flagged
// - double talk threshold resets to 4800h
// - thresholds 16 bits, fraction times 32768
// - residual below suppression level is removed
// - comfort noise matched to background noise
// - suppressor off bit kills threshold and noise
// - comfort noise off bit keeps suppressor
// - phase mode: 1s tone plus reversal
// - plain mode: 2100 Hz tone for 400ms
// - two detectors per channel, flag, irq low
// - flag holds until 400ms quiet, then irq
// - phase ignore bit selects plain mode
// - auto bypass bit lets detector bypass
// - narrow-band guard halts adaptation, can disable
// - DC removal on both inputs, can disable
`ifndef ECG_MAP_VH
`define ECG_MAP_VH
`define ECG_GROUPS 16
`define ECG_CANCELLERS 32
`define ECG_FS_HZ 8000
`define ECG_TAIL_MS 64
`define ECG_SEC_TAPS (`ECG_TAIL_MS * `ECG_FS_HZ / 1000)
`define ECG_TAPS (2 * `ECG_SEC_TAPS)
// Host address: bit 5 picks canceller B, low bits the register
`define ECG_CTRL1 5'h00
`define ECG_CTRL2 5'h01
`define ECG_STAT 5'h02
`define ECG_DOUBLE_TALK_THRESHOLD 5'h14
`define ECG_NLPT 5'h18
// First control register fields
`define ECG_C1_EXT 0
`define ECG_C1_CNOFF 1
`define ECG_C1_BBM 2
// Second control register fields
`define ECG_C2_ADOFF 0
`define ECG_C2_BYP 1
`define ECG_C2_NBOFF 2
`define ECG_C2_DCOFF 3
`define ECG_C2_NLPOFF 4
`define ECG_C2_AUTO 5
`define ECG_C2_PHIGN 6
// Status fields
`define ECG_ST_TD 0
`define ECG_ST_CONVERGENCE_SPEED_FLAG 1
`define ECG_ST_DT 2
`define ECG_ST_NLP 3
// Reset values
`define ECG_DOUBLE_TALK_THRESHOLD_RST 16'h4800
`define ECG_NLPT_RST 16'h2000
`define ECG_Q15 15
// Tone timing in ms, counted in samples
`define ECG_TONE_MS 400
`define ECG_PR_MS 1000
`define ECG_PR_GAP_MS 425
`define ECG_REL_MS 400
`define ECG_TONE_N (`ECG_TONE_MS * `ECG_FS_HZ / 1000)
`define ECG_PR_N (`ECG_PR_MS * `ECG_FS_HZ / 1000)
`define ECG_PR_GAP_N (`ECG_PR_GAP_MS * `ECG_FS_HZ / 1000)
`define ECG_REL_N (`ECG_REL_MS * `ECG_FS_HZ / 1000)
// Tone window: 10ms, 2100 Hz gives 42 sign changes
`define ECG_WIN 7'd79
`define ECG_ZC_LO 7'd40
`define ECG_ZC_HI 7'd44
`define ECG_ZC_NB 7'd4
`define ECG_TONE_LVL 16'h0100
`define ECG_REL_LO 16'h0300
`define ECG_REL_HI 16'h0200
// Adaptation step shifts, Q15 included
`define ECG_MU_FAST 5'd22
`define ECG_MU_SLOW 5'd25
`endif

/* core/ecg_core.v */
// Echo canceller group: two cancellers, shared filter, output FIFO
`timescale 1ns/1ps
`include "ecg_map.vh"

module ecg_fifo #(
   parameter W = 33,
   parameter D = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   localparam [AW:0] DN = D[AW:0];
   localparam [AW-1:0] LAST = D[AW-1:0] - 1'b1;
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0] cnt_reg;
   wire wr = in_valid && in_ready;
   wire rd = out_valid && out_ready;

   // Honest flags from the fill count
   assign in_ready = (cnt_reg != DN);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem[rp_reg];

   // Storage has no reset; the count guards stale words
   always @(posedge mclk) begin
      if (wr)
         mem[wp_reg] <= in_data;
   end

   // Pointers wrap at depth, not power of two
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (wr)
            wp_reg <= (wp_reg == LAST) ? {AW{1'b0}} : wp_reg + 1'b1;
         if (rd)
            rp_reg <= (rp_reg == LAST) ? {AW{1'b0}} : rp_reg + 1'b1;
         if (wr && !rd)
            cnt_reg <= cnt_reg + 1'b1;
         else if (rd && !wr)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule // ecg_fifo

module ecg_core #(
   parameter [13:0] TONE_N = `ECG_TONE_N,
   parameter [13:0] PR_N = `ECG_PR_N,
   parameter [13:0] PR_GAP_N = `ECG_PR_GAP_N,
   parameter [13:0] REL_N = `ECG_REL_N,
   parameter FIFO_D = 8
) (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // Host port (pins)
   input wire hst_cs_b,
   input wire hst_we,
   input wire [5:0] hst_addr,
   input wire [15:0] hst_wdata,
   output reg [15:0] hst_rdata,
   output reg hst_rdata_oe_b,
   output wire irq_b,
   // Linear samples in
   input wire smp_valid,
   input wire smp_chan,
   input wire [15:0] smp_rin,
   input wire [15:0] smp_sin,
   output wire smp_ready,
   // Processed samples out
   output wire out_valid,
   output wire out_chan,
   output wire [15:0] out_rout,
   output wire [15:0] out_sout,
   input wire out_ready
);
   localparam [2:0] S_CLR = 3'h0, S_IDLE = 3'h1, S_HWR = 3'h2, S_MAC = 3'h3;
   localparam [2:0] S_ERR = 3'h4, S_ADP = 3'h5, S_PUSH = 3'h6;

   function [15:0] sat17;
      input [16:0] v;
      sat17 = (v[16] ^ v[15]) ? {v[16], {15{~v[16]}}} : v[15:0];
   endfunction
   function [15:0] abs16;
      input [15:0] v;
      abs16 = v[15] ? ((v == 16'h8000) ? 16'h7fff : (~v + 16'h0001)) : v;
   endfunction
   function [15:0] pkf;
      input [15:0] l;
      input [15:0] a;
      pkf = (a > l) ? a : (l - {5'h00, l[15:5]});
   endfunction

   // Per canceller registers and state, index 0 is A
   reg [7:0] ctl1 [0:1];
   reg [7:0] ctl2 [0:1];
   reg [15:0] dtt [0:1];
   reg [15:0] nlt [0:1];
   reg [15:0] dcr [0:1];
   reg [15:0] dcs [0:1];
   reg [15:0] lvr [0:1];
   reg [15:0] lvs [0:1];
   reg [1:0] td_reg, ev_reg, convergence_speed_flag_reg, dts_reg, nla_reg;
   // Per filter section state
   reg [9:0] ptr [0:1];
   reg [15:0] lve [0:1];
   reg [15:0] nf [0:1];
   reg signed [15:0] hist [0:1023];
   reg signed [15:0] coef [0:1023];
   // Sequencer
   reg [2:0] st_reg;
   reg cc_reg, j_reg, adp_reg, slow_reg;
   reg [10:0] k_reg;
   reg signed [39:0] acc_reg;
   reg [15:0] err_reg, f_r, f_s, res0, res1, lfsr, cns;
   // Host synchronisers
   reg [2:0] cs_s;
   reg [22:0] hb1, hb2;
   integer n;

   wire [3:0] trig;
   wire [3:0] qok;
   wire [3:0] nbq;
   wire fifo_rdy;

   // Host access taken on synced falling select
   wire take = cs_s[2] & ~cs_s[1];
   wire hwe = hb2[22];
   wire hc = hb2[21];
   wire [4:0] ho = hb2[20:16];
   wire [15:0] hwd = hb2[15:0];
   wire stat_rd = take & ~hwe & (ho == `ECG_STAT);

   // Sample accept and DC removal on both inputs
   wire acc = (st_reg == S_IDLE) & smp_valid;
   wire dcoff = ctl2[smp_chan][`ECG_C2_DCOFF];
   wire [15:0] rin_f = dcoff ? smp_rin :
      sat17({smp_rin[15], smp_rin} - {dcr[smp_chan][15], dcr[smp_chan]});
   wire [15:0] sin_f = dcoff ? smp_sin :
      sat17({smp_sin[15], smp_sin} - {dcs[smp_chan][15], dcs[smp_chan]});
   wire byp = ctl2[smp_chan][`ECG_C2_BYP] |
      (ctl2[smp_chan][`ECG_C2_AUTO] & td_reg[smp_chan]);

   // Group arrangement and job descriptor
   wire b2b = ctl1[0][`ECG_C1_BBM] & ctl1[1][`ECG_C1_BBM];
   wire ext = ctl1[0][`ECG_C1_EXT] & ~b2b;
   wire jsec = b2b ? j_reg : (ext ? 1'b0 : cc_reg);
   wire jtr = b2b & ~j_reg;
   wire [10:0] jlast = ext ? 11'h3ff : 11'h1ff;
   wire [9:0] mask = ext ? 10'h3ff : 10'h1ff;
   wire [9:0] pp = ptr[jsec];
   wire [9:0] ha = {jsec, 9'h000} | ((pp - k_reg[9:0]) & mask);
   wire [9:0] ca = {jsec, 9'h000} | (k_reg[9:0] & mask);
   wire [15:0] jref = jtr ? f_s : f_r;
   wire [15:0] jtgt = jtr ? f_r : f_s;
   wire [15:0] lr = jtr ? lvs[cc_reg] : lvr[cc_reg];
   wire [15:0] lt = jtr ? lvr[cc_reg] : lvs[cc_reg];

   // FIR product and error
   wire signed [31:0] prod = hist[ha] * coef[ca];
   wire [16:0] est = acc_reg[31:15];
   wire [15:0] e = sat17({jtgt[15], jtgt} - est);
   // Double talk: Lt > Lr + 20log(thr) as linear compare
   wire [31:0] rdt = lr * dtt[cc_reg];
   wire dt = {1'b0, lt, 15'h0000} > rdt;
   wire slow = ~dt & ({lt, 16'h0000} > rdt);
   wire nbon = nbq[{cc_reg, 1'b0}] & ~ctl2[cc_reg][`ECG_C2_NBOFF];
   wire gate = ~ctl2[cc_reg][`ECG_C2_ADOFF] & ~dt & ~nbon;
   // Suppressor: error below Lr + 20log(thr)
   wire [31:0] rnl = lr * nlt[cc_reg];
   wire residual_suppressor = ~ctl2[cc_reg][`ECG_C2_NLPOFF] &
      ({1'b0, lve[jsec], 15'h0000} < rnl);
   wire [31:0] cnraw = $signed(lfsr) * $signed({1'b0, nf[jsec][15:1]});
   wire [15:0] eout = residual_suppressor ? (ctl1[cc_reg][`ECG_C1_CNOFF] ? 16'h0000 : cns) : e;
   // Error-times-data step, slowed when uncertain
   wire signed [31:0] dprod = $signed(err_reg) * hist[ha];
   wire signed [31:0] dlt = dprod >>> (slow_reg ? `ECG_MU_SLOW : `ECG_MU_FAST);
   wire fin = (k_reg == jlast) | ((st_reg == S_ADP) & ~adp_reg);

   assign smp_ready = (st_reg == S_IDLE);
   assign irq_b = ~|ev_reg;

   // One tone detector per input per canceller
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_td
         localparam [0:0] C = (gi > 1);
         localparam [0:0] P = (gi % 2 == 1);
         reg sg, tone, nb, rev, lat;
         reg [2:0] ivl;
         reg [6:0] zc, zcp, win;
         reg [13:0] tcnt, srev, qcnt;
         reg [15:0] pk, lp, llo, lhi;
         wire en = acc & (smp_chan == C);
         wire [15:0] x = P ? sin_f : rin_f;
         wire xc = x[15] ^ sg;
         wire [6:0] zn = zc + {6'h00, xc};
         wire [6:0] zd = (zn > zcp) ? (zn - zcp) : (zcp - zn);
         wire [15:0] hi = sat17({x[15], x} - {lp[15], lp});
         wire cond = ctl2[C][`ECG_C2_PHIGN] ? (tcnt >= TONE_N) :
            ((tcnt >= PR_N) & rev);
         assign trig[gi] = en & cond & ~lat;
         assign qok[gi] = (qcnt >= REL_N);
         assign nbq[gi] = nb;
         // Zero-crossing window, reversal and band levels
         always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               sg <= 1'b0;
               tone <= 1'b0;
               nb <= 1'b0;
               rev <= 1'b0;
               lat <= 1'b0;
               ivl <= 3'h0;
               zc <= 7'h00;
               zcp <= 7'h00;
               win <= 7'h00;
               tcnt <= 14'h0000;
               srev <= 14'h0000;
               qcnt <= 14'h0000;
               pk <= 16'h0000;
               lp <= 16'h0000;
               llo <= 16'h0000;
               lhi <= 16'h0000;
            end else if (en) begin
               sg <= x[15];
               ivl <= xc ? 3'h1 : ((ivl == 3'h7) ? ivl : ivl + 3'h1);
               if (win == `ECG_WIN) begin
                  tone <= (zn >= `ECG_ZC_LO) & (zn <= `ECG_ZC_HI) &
                     (pk >= `ECG_TONE_LVL);
                  nb <= (zd <= 7'h01) & (zn >= `ECG_ZC_NB) & (pk >= `ECG_TONE_LVL);
                  zcp <= zn;
                  zc <= 7'h00;
                  pk <= 16'h0000;
                  win <= 7'h00;
               end else begin
                  zc <= zn;
                  pk <= (abs16(x) > pk) ? abs16(x) : pk;
                  win <= win + 7'h01;
               end
               // A reversal stretches one half cycle to three samples
               if (!tone) begin
                  tcnt <= 14'h0000;
                  srev <= 14'h0000;
                  rev <= 1'b0;
                  lat <= 1'b0;
               end else begin
                  tcnt <= (tcnt == 14'h3fff) ? tcnt : tcnt + 14'h0001;
                  if (xc && (ivl >= 3'h3) && (srev >= PR_GAP_N)) begin
                     rev <= 1'b1;
                     srev <= 14'h0000;
                  end else if (srev != 14'h3fff) begin
                     srev <= srev + 14'h0001;
                  end
                  if (cond)
                     lat <= 1'b1;
               end
               // Split at a few hundred Hz for the release levels
               lp <= sat17({lp[15], lp} + {{3{hi[15]}}, hi[15:2]});
               llo <= pkf(llo, abs16(lp));
               lhi <= pkf(lhi, abs16(hi));
               if ((llo < `ECG_REL_LO) && (lhi < `ECG_REL_HI))
                  qcnt <= (qcnt == 14'h3fff) ? qcnt : qcnt + 14'h0001;
               else
                  qcnt <= 14'h0000;
            end
         end
      end
   endgenerate

   // Filter memories: cleared after reset, then history and taps
   always @(posedge mclk) begin
      if (st_reg == S_CLR) begin
         hist[k_reg[9:0]] <= 16'h0000;
         coef[k_reg[9:0]] <= 16'h0000;
      end
      if (st_reg == S_HWR)
         hist[{jsec, 9'h000} | (pp & mask)] <= jref;
      if ((st_reg == S_ADP) && adp_reg)
         coef[ca] <= coef[ca] + dlt[15:0];
   end

   // Host synchronisers; first stage feeds only the second
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cs_s <= 3'h7;
         hb1 <= 23'h000000;
         hb2 <= 23'h000000;
      end else begin
         cs_s <= {cs_s[1:0], hst_cs_b};
         hb1 <= {hst_we, hst_addr, hst_wdata};
         hb2 <= hb1;
      end
   end

   // Registers, detector flags and the sample sequencer
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (n = 0; n < 2; n = n + 1) begin
            ctl1[n] <= 8'h00;
            ctl2[n] <= 8'h00;
            dtt[n] <= `ECG_DOUBLE_TALK_THRESHOLD_RST;
            nlt[n] <= `ECG_NLPT_RST;
            dcr[n] <= 16'h0000;
            dcs[n] <= 16'h0000;
            lvr[n] <= 16'h0000;
            lvs[n] <= 16'h0000;
            ptr[n] <= 10'h000;
            lve[n] <= 16'h0000;
            nf[n] <= 16'h0000;
         end
         td_reg <= 2'h0;
         ev_reg <= 2'h0;
         convergence_speed_flag_reg <= 2'h0;
         dts_reg <= 2'h0;
         nla_reg <= 2'h0;
         st_reg <= S_CLR;
         cc_reg <= 1'b0;
         j_reg <= 1'b0;
         adp_reg <= 1'b0;
         slow_reg <= 1'b0;
         k_reg <= 11'h000;
         acc_reg <= 40'h0000000000;
         err_reg <= 16'h0000;
         f_r <= 16'h0000;
         f_s <= 16'h0000;
         res0 <= 16'h0000;
         res1 <= 16'h0000;
         lfsr <= 16'hace1;
         cns <= 16'h0000;
         hst_rdata <= 16'h0000;
         hst_rdata_oe_b <= 1'b1;
      end else begin
         // Host reads and writes, 16-bit thresholds
         hst_rdata_oe_b <= cs_s[1];
         if (take && hwe) begin
            if (ho == `ECG_CTRL1)
               ctl1[hc] <= hwd[7:0];
            if (ho == `ECG_CTRL2)
               ctl2[hc] <= hwd[7:0];
            if (ho == `ECG_DOUBLE_TALK_THRESHOLD)
               dtt[hc] <= hwd;
            if (ho == `ECG_NLPT)
               nlt[hc] <= hwd;
         end
         if (take && !hwe) begin
            case (ho)
               `ECG_CTRL1: hst_rdata <= {8'h00, ctl1[hc]};
               `ECG_CTRL2: hst_rdata <= {8'h00, ctl2[hc]};
               `ECG_STAT: hst_rdata <= {12'h000, nla_reg[hc], dts_reg[hc],
                  convergence_speed_flag_reg[hc], td_reg[hc]};
               `ECG_DOUBLE_TALK_THRESHOLD: hst_rdata <= dtt[hc];
               `ECG_NLPT: hst_rdata <= nlt[hc];
               default: hst_rdata <= 16'h0000;
            endcase
         end
         // Tone flag holds until quiet; events win over a status read
         for (n = 0; n < 2; n = n + 1) begin
            if (trig[2*n] | trig[2*n+1])
               td_reg[n] <= 1'b1;
            else if (td_reg[n] & qok[2*n] & qok[2*n+1])
               td_reg[n] <= 1'b0;
            if (trig[2*n] | trig[2*n+1] | (td_reg[n] & qok[2*n] & qok[2*n+1]))
               ev_reg[n] <= 1'b1;
            else if (stat_rd && (hc == n[0]))
               ev_reg[n] <= 1'b0;
         end
         case (st_reg)
            S_CLR: begin
               k_reg <= k_reg + 11'h001;
               if (k_reg == 11'h3ff) begin
                  k_reg <= 11'h000;
                  st_reg <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (acc) begin
                  if (!dcoff) begin
                     dcr[smp_chan] <= dcr[smp_chan] + {{6{rin_f[15]}}, rin_f[15:6]};
                     dcs[smp_chan] <= dcs[smp_chan] + {{6{sin_f[15]}}, sin_f[15:6]};
                  end
                  lvr[smp_chan] <= pkf(lvr[smp_chan], abs16(rin_f));
                  lvs[smp_chan] <= pkf(lvs[smp_chan], abs16(sin_f));
                  f_r <= rin_f;
                  f_s <= sin_f;
                  res0 <= smp_rin;
                  res1 <= smp_sin;
                  cc_reg <= smp_chan;
                  j_reg <= 1'b0;
                  // Slot B carries nothing useful when A and B are joined
                  if (byp || (smp_chan && (ext || b2b)))
                     st_reg <= S_PUSH;
                  else
                     st_reg <= S_HWR;
               end
            end
            S_HWR: begin
               acc_reg <= 40'h0000000000;
               k_reg <= 11'h000;
               st_reg <= S_MAC;
            end
            S_MAC: begin
               acc_reg <= acc_reg + {{8{prod[31]}}, prod};
               k_reg <= k_reg + 11'h001;
               if (fin)
                  st_reg <= S_ERR;
            end
            S_ERR: begin
               err_reg <= e;
               adp_reg <= gate;
               slow_reg <= slow;
               convergence_speed_flag_reg[cc_reg] <= slow;
               dts_reg[cc_reg] <= dt;
               nla_reg[cc_reg] <= residual_suppressor;
               lve[jsec] <= pkf(lve[jsec], abs16(e));
               // Noise floor: falls at once, creeps up slowly
               nf[jsec] <= (lt < nf[jsec]) ? lt : nf[jsec] + 16'h0001;
               lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
               cns <= sat17({cns[15], cns} + {{2{cnraw[30]}}, cnraw[30:16]});
               if (jtr)
                  res0 <= eout;
               else
                  res1 <= eout;
               k_reg <= 11'h000;
               st_reg <= S_ADP;
            end
            S_ADP: begin
               k_reg <= k_reg + 11'h001;
               if (fin) begin
                  ptr[jsec] <= {jsec, 9'h000} | ((pp + 10'h001) & mask);
                  if (b2b && !j_reg) begin
                     j_reg <= 1'b1;
                     st_reg <= S_HWR;
                  end else begin
                     st_reg <= S_PUSH;
                  end
               end
            end
            S_PUSH: begin
               if (fifo_rdy)
                  st_reg <= S_IDLE;
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   // Output buffer; a full buffer holds the sequencer in push
   ecg_fifo #(.W(33), .D(FIFO_D), .AW(3)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(st_reg == S_PUSH),
      .in_ready(fifo_rdy),
      .in_data({cc_reg, res0, res1}),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data({out_chan, out_rout, out_sout})
   );
endmodule // ecg_core

/* bench/ecg_core_chk.sv */
// Port checker for the echo canceller group core
`timescale 1ns/1ps
module ecg_core_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Host port
   input wire logic hst_cs_b,
   input wire logic [15:0] hst_rdata,
   input wire logic hst_rdata_oe_b,
   input wire logic irq_b,
   // Sample streams
   input wire logic smp_valid,
   input wire logic smp_ready,
   input wire logic out_valid,
   input wire logic out_chan,
   input wire logic [15:0] out_rout,
   input wire logic [15:0] out_sout,
   input wire logic out_ready
);
   logic [3:0] cs_age_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Cycles since the host last selected, saturating
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         cs_age_reg <= 4'hf;
      else if (!hst_cs_b)
         cs_age_reg <= 4'h0;
      else if (cs_age_reg != 4'hf)
         cs_age_reg <= cs_age_reg + 4'h1;
   end
   property p_oe_on; $fell(hst_cs_b) |-> ##[2:3] !hst_rdata_oe_b; endproperty
   a_oe_on: assert property (p_oe_on) else $error("read enable late");
   property p_oe_sel; !hst_cs_b [*4] |-> !hst_rdata_oe_b; endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("read enable dropped");
   property p_oe_off; hst_cs_b [*4] |-> hst_rdata_oe_b; endproperty
   a_oe_off: assert property (p_oe_off) else $error("read enable stuck");
   property p_rd_hold; hst_cs_b [*6] |-> $stable(hst_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   // Pending events clear only through a status read
   property p_irq_clr; $rose(irq_b) |-> cs_age_reg < 4'h8; endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("event lost");
   property p_out_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_rout) && $stable(out_sout)
         && $stable(out_chan);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output word moved");
   property p_out_pop; $fell(out_valid) |-> $past(out_ready); endproperty
   a_out_pop: assert property (p_out_pop) else $error("output word dropped");
   property p_take; smp_valid && smp_ready |=> !smp_ready; endproperty
   a_take: assert property (p_take) else $error("taken twice");
endmodule // ecg_core_chk

bind ecg_core ecg_core_chk u_chk (.mclk(mclk), .rst_b(rst_b), .hst_cs_b(hst_cs_b),
   .hst_rdata(hst_rdata), .hst_rdata_oe_b(hst_rdata_oe_b), .irq_b(irq_b),
   .smp_valid(smp_valid), .smp_ready(smp_ready), .out_valid(out_valid),
   .out_chan(out_chan), .out_rout(out_rout), .out_sout(out_sout), .out_ready(out_ready));

/* bench/ecg_stream_peer.sv */
// Sample source and sink on the far side of the core
`timescale 1ns/1ps
module ecg_stream_peer (
   // Clock and bench control
   input wire logic mclk,
   input wire logic stall,
   // Toward the core
   output logic smp_valid,
   output logic smp_chan,
   output logic [15:0] smp_rin,
   output logic [15:0] smp_sin,
   input wire logic smp_ready,
   // From the core
   input wire logic out_valid,
   input wire logic out_chan,
   input wire logic [15:0] out_rout,
   input wire logic [15:0] out_sout,
   output logic out_ready
);
   logic [32:0] rx_q[$];
   initial begin
      smp_valid = 1'b0;
      smp_chan = 1'b0;
      smp_rin = 16'h0000;
      smp_sin = 16'h0000;
   end
   // Sink holds off on request, keeps words in arrival order
   assign out_ready = !stall;
   always @(posedge mclk) begin
      if (out_valid && out_ready)
         rx_q.push_back({out_chan, out_rout, out_sout});
   end
   // Offer held until taken or 4000 cycles pass; idle lines scrambled so stale data cannot match
   task automatic send(input logic ch, input logic [15:0] r, input logic [15:0] s,
                       output bit ok);
      int n;
      ok = 1'b0;
      @(negedge mclk);
      smp_valid = 1'b1;
      smp_chan = ch;
      smp_rin = r;
      smp_sin = s;
      for (n = 0; n < 4000 && !ok; n++) begin
         @(posedge mclk);
         ok = smp_ready;
      end
      @(negedge mclk);
      smp_valid = 1'b0;
      smp_rin = ~r;
      smp_sin = ~s;
   endtask
endmodule // ecg_stream_peer

/* bench/tb_top.sv */
// Self-checking bench for the echo canceller group core
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hst_cs_b = 1'b1;
   logic hst_we = 1'b0;
   logic [5:0] hst_addr = 6'h00;
   logic [15:0] hst_wdata = 16'h0000;
   logic stall = 1'b0;
   wire [15:0] hst_rdata, smp_rin, smp_sin, out_rout, out_sout;
   wire hst_rdata_oe_b, irq_b, smp_valid, smp_chan, smp_ready, out_valid, out_chan, out_ready;
   int failures = 0;
   int n_checks = 0;
   logic [15:0] rd;
   logic [32:0] w;
   bit ok;
   int i;
   always #5 mclk = ~mclk;
   // Short tone counts keep the run brief
   ecg_core #(.TONE_N(14'd40), .PR_N(14'd80), .PR_GAP_N(14'd20), .REL_N(14'd40)) dut (
      .mclk(mclk), .rst_b(rst_b), .hst_cs_b(hst_cs_b), .hst_we(hst_we), .hst_addr(hst_addr),
      .hst_wdata(hst_wdata), .hst_rdata(hst_rdata), .hst_rdata_oe_b(hst_rdata_oe_b),
      .irq_b(irq_b), .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_rin(smp_rin),
      .smp_sin(smp_sin), .smp_ready(smp_ready), .out_valid(out_valid), .out_chan(out_chan),
      .out_rout(out_rout), .out_sout(out_sout), .out_ready(out_ready));
   ecg_stream_peer peer (.mclk(mclk), .stall(stall), .smp_valid(smp_valid),
      .smp_chan(smp_chan), .smp_rin(smp_rin), .smp_sin(smp_sin), .smp_ready(smp_ready),
      .out_valid(out_valid), .out_chan(out_chan), .out_rout(out_rout),
      .out_sout(out_sout), .out_ready(out_ready));
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Host cycle: lines settle before select, select held past the answer
   task automatic xfer(input logic we, input logic [5:0] a, input logic [15:0] d);
      @(negedge mclk);
      hst_we = we;
      hst_addr = a;
      hst_wdata = d;
      repeat (3) @(negedge mclk);
      hst_cs_b = 1'b0;
      repeat (6) @(negedge mclk);
      rd = hst_rdata;
      hst_cs_b = 1'b1;
      repeat (4) @(negedge mclk);
   endtask
   task automatic rd_chk(input string nm, input logic [5:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      check(nm, e, rd);
   endtask
   task automatic snd(input logic ch, input logic [15:0] r, input logic [15:0] s);
      peer.send(ch, r, s, ok);
      check("sample_taken", 16'h1, {15'h0, ok});
      if (!ok)
         finish_test;
   endtask
   task automatic wait_rx(input int n);
      for (i = 0; i < 5000 && peer.rx_q.size() < n; i++)
         @(negedge mclk);
      check("rx_count", 16'(n), 16'(peer.rx_q.size()));
      if (peer.rx_q.size() < n)
         finish_test;
   endtask
   function automatic logic [15:0] tone(input int k);
      return 16'($rtoi(8192.0 * $sin(2.0 * 3.14159265 * 2100.0 * k / 8000.0)));
   endfunction
   // Watchdog against a hang
   initial begin
      #900000;
      failures++;
      $display("ERROR watchdog expected done seen hang");
      finish_test;
   end
   initial begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      rd_chk("double_talk_threshold_a", 6'h14, 16'h4800);
      rd_chk("double_talk_threshold_b", 6'h34, 16'h4800);
      rd_chk("nlpt_a", 6'h18, 16'h2000);
      rd_chk("ctrl2_a", 6'h01, 16'h0000);
      xfer(1'b1, 6'h34, 16'hffff);
      rd_chk("double_talk_threshold_b_w", 6'h34, 16'hffff);
      xfer(1'b1, 6'h38, 16'h0001);
      rd_chk("nlpt_b_w", 6'h38, 16'h0001);
      xfer(1'b1, 6'h03, 16'habcd);
      rd_chk("unmapped", 6'h03, 16'h0000);
      $display("Test registers done");
      // Silent receive path: send passes unchanged, double talk flagged
      xfer(1'b1, 6'h01, 16'h0118);
      rd_chk("ctrl2_upper", 6'h01, 16'h0018);
      xfer(1'b1, 6'h21, 16'h0018);
      for (int c = 0; c < 2; c++) begin
         snd(c[0], 16'h0000, 16'h1000);
         wait_rx(1);
         w = peer.rx_q.pop_front();
         check("sout", 16'h1000, w[15:0]);
         check("rout", 16'h0000, w[31:16]);
         check("chan", {15'h0, c[0]}, {15'h0, w[32]});
         xfer(1'b0, {c[0], 5'h02}, 16'h0000);
         check("dt_flag", 16'h1, {15'h0, rd[2]});
      end
      $display("Test cancel path done");
      // Bypass with the sink stalled until the buffer refuses
      xfer(1'b1, 6'h01, 16'h0002);
      stall = 1'b1;
      for (int k = 0; k < 9; k++)
         snd(1'b0, 16'(k), ~16'(k));
      repeat (20) @(negedge mclk);
      check("ready_full", 16'h0, {15'h0, smp_ready});
      stall = 1'b0;
      wait_rx(9);
      for (int k = 0; k < 9; k++) begin
         w = peer.rx_q.pop_front();
         check("fifo_rout", 16'(k), w[31:16]);
         check("fifo_sout", ~16'(k), w[15:0]);
      end
      $display("Test buffer done");
      // Steady tone without reversal in phase mode, then plain mode
      for (int k = 0; k < 400; k++)
         snd(1'b0, tone(k), 16'h0000);
      check("irq_phase", 16'h1, {15'h0, irq_b});
      xfer(1'b1, 6'h01, 16'h0042);
      for (int k = 400; k < 800; k++)
         snd(1'b0, tone(k), 16'h0000);
      check("irq_tone", 16'h0, {15'h0, irq_b});
      xfer(1'b0, 6'h02, 16'h0000);
      check("td_set", 16'h1, {15'h0, rd[0]});
      check("irq_clear", 16'h1, {15'h0, irq_b});
      for (int k = 0; k < 600; k++)
         snd(1'b0, 16'h0000, 16'h0000);
      check("irq_release", 16'h0, {15'h0, irq_b});
      xfer(1'b0, 6'h02, 16'h0000);
      check("td_clear", 16'h0, {15'h0, rd[0]});
      peer.rx_q.delete();
      $display("Test tone done");
      finish_test;
   end
endmodule // tb_top
